// ---- core/tccp_timer.sv ----
// What this block does
// - one counter per instance, width 16 or 32 set by parameter
// - up to three channels, each capture, compare or pwm
// - capture copies counter into channel buffer on a rising edge of the channel's capture input
// - compare drives channel output from counter against threshold
// - pwm output follows successive compare values software writes
// - optional dead time keeps complementary pwm outputs never both active
// - counts time or external events; sends timed triggers to network
//
// Purpose: general timer with capture, compare and pwm channels
// Assumes: control comes on plain ports; event inputs are asynchronous
// Notes:   pwm values load at wrap so waveforms stay glitch-free; compare values load one cycle after the write
`timescale 1ns/1ps
`include "tccp_cfg.svh"

module tccp_timer
#(
   parameter int CNT_W   = `TCCP_CNT_W_DEF,
   parameter int NCH     = `TCCP_NCH_DEF,
   parameter bit DT_EN   = 1'b1
)
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // counter control
   input  wire logic                      cnt_en,
   input  wire logic                      cnt_ext_sel,
   input  wire logic                      ext_event_pin,
   input  wire logic [CNT_W-1:0]          top_val,
   output logic      [CNT_W-1:0]          cnt_val,
   output logic                           ovf_flag,
   input  wire logic                      ovf_clr,
   // per channel configuration, dead time shared by all channels
   input  wire tccp_pkg::tccp_mode_t      ch_mode    [NCH],
   input  wire logic [CNT_W-1:0]          ch_cmp_val [NCH],
   input  wire logic [NCH-1:0]            ch_cmp_wr,
   input  wire logic [`TCCP_DT_W-1:0]     dt_cycles,
   // per channel capture inputs and results
   input  wire logic [NCH-1:0]            ch_cap_pin,
   output logic      [CNT_W-1:0]          ch_cap_buf [NCH],
   output logic      [NCH-1:0]            ch_cap_valid,
   // per channel outputs
   output logic      [NCH-1:0]            ch_out,
   output logic      [NCH-1:0]            ch_out_n,
   // event network producer strobes
   output logic                           ern_ovf_evt,
   output logic      [NCH-1:0]            ern_ch_evt
);
   import tccp_pkg::*;

   logic [1:0]       ext_sync_r;
   logic             ext_prev_r;
   logic             tick;
   logic             wrap;
   logic [CNT_W-1:0] cnt_r;
   logic             ovf_r;
   logic             ovf_evt_r;

   // two-stage synchroniser plus edge detect on the external count source
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ext_sync_r <= 2'h0;
         ext_prev_r <= 1'b0;
      end
      else
      begin
         ext_sync_r <= {ext_sync_r[0], ext_event_pin};
         ext_prev_r <= ext_sync_r[1];
      end
   end

   // count clock cycles or external rising edges
   assign tick = cnt_en & (cnt_ext_sel ? (ext_sync_r[1] & ~ext_prev_r)
                                       : 1'b1);
   assign wrap = tick & (cnt_r == top_val);

   // main counter
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_r <= '0;
      else if (wrap)
         cnt_r <= '0;
      else if (tick)
         cnt_r <= cnt_r + 1'b1;
   end

   // sticky overflow, a new wrap wins over the clear
   always_ff @(posedge clk)
   begin
      if (srst)
         ovf_r <= 1'b0;
      else if (wrap)
         ovf_r <= 1'b1;
      else if (ovf_clr)
         ovf_r <= 1'b0;
   end

   // overflow trigger pulse to the event network
   always_ff @(posedge clk)
   begin
      if (srst)
         ovf_evt_r <= 1'b0;
      else
         ovf_evt_r <= wrap;
   end

   assign cnt_val     = cnt_r;
   assign ovf_flag    = ovf_r;
   assign ern_ovf_evt = ovf_evt_r;

   // per channel logic
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         logic [1:0]          cap_sync_r;
         logic                cap_prev_r;
         logic                cap_edge;
         logic [CNT_W-1:0]    cap_r;
         logic                cap_v_r;
         logic [CNT_W-1:0]    cmp_buf_r;
         logic                cmp_pend_r;
         logic [CNT_W-1:0]    cmp_act_r;
         logic                raw;
         logic                raw_prev_r;
         logic                is_pwm;
         logic [`TCCP_DT_W-1:0] dt_cnt_r;
         logic                out_r;
         logic                out_n_r;
         logic                evt_r;

         // synchronise capture input, detect rising edge
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               cap_sync_r <= 2'h0;
               cap_prev_r <= 1'b0;
            end
            else
            begin
               cap_sync_r <= {cap_sync_r[0], ch_cap_pin[g]};
               cap_prev_r <= cap_sync_r[1];
            end
         end
         assign cap_edge = cap_sync_r[1] & ~cap_prev_r;

         // capture buffer
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               cap_r   <= '0;
               cap_v_r <= 1'b0;
            end
            else if (ch_mode[g] == TCCP_MODE_CAPTURE && cap_edge)
            begin
               cap_r   <= cnt_r;
               cap_v_r <= 1'b1;
            end
         end

         // compare value: buffered, active one cycle after the write in compare mode, held until wrap in pwm mode
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               cmp_buf_r  <= '0;
               cmp_pend_r <= 1'b0;
               cmp_act_r  <= '0;
            end
            else
            begin
               if (ch_cmp_wr[g])
               begin
                  cmp_buf_r  <= ch_cmp_val[g];
                  cmp_pend_r <= 1'b1;
               end
               else if (wrap || ch_mode[g] != TCCP_MODE_PWM)
                  cmp_pend_r <= 1'b0;
               if (cmp_pend_r && (wrap || ch_mode[g] != TCCP_MODE_PWM))
                  cmp_act_r <= cmp_buf_r;
            end
         end

         // raw channel level from mode
         always_comb
         begin
            unique case (ch_mode[g])
               TCCP_MODE_COMPARE: raw = (cnt_r >= cmp_act_r);
               TCCP_MODE_PWM:     raw = (cnt_r <  cmp_act_r);
               default:           raw = 1'b0;
            endcase
         end

         // dead time belongs to the pwm pair only; compare output stays prompt
         assign is_pwm = (ch_mode[g] == TCCP_MODE_PWM);

         // dead-time insertion on complementary pair
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               raw_prev_r <= 1'b0;
               dt_cnt_r   <= '0;
               out_r      <= 1'b0;
               out_n_r    <= 1'b0;
            end
            else
            begin
               raw_prev_r <= raw;
               if (DT_EN && is_pwm && raw != raw_prev_r)
               begin
                  out_r    <= 1'b0;
                  out_n_r  <= 1'b0;
                  dt_cnt_r <= dt_cycles;
               end
               else if (DT_EN && is_pwm && dt_cnt_r != '0)
                  dt_cnt_r <= dt_cnt_r - 1'b1;
               else
               begin
                  out_r    <= raw;
                  out_n_r  <= is_pwm & ~raw;
                  dt_cnt_r <= '0; // no stale gap after a mode change
               end
            end
         end

         // trigger strobe on compare match or capture
         always_ff @(posedge clk)
         begin
            if (srst)
               evt_r <= 1'b0;
            else
               evt_r <= (ch_mode[g] == TCCP_MODE_CAPTURE) ? cap_edge
                        : (tick && cnt_r == cmp_act_r);
         end

         assign ch_cap_buf[g]   = cap_r;
         assign ch_cap_valid[g] = cap_v_r;
         assign ch_out[g]       = out_r;
         assign ch_out_n[g]     = out_n_r;
         assign ern_ch_evt[g]   = evt_r;
      end
   endgenerate
endmodule

// ---- core/tccp_cfg.svh ----
// Purpose: constants for the timer capture/compare/pwm block
// Assumes: included by its bare name
// Notes:   mode codes live in the package as an enum
`ifndef TCCP_CFG_SVH
`define TCCP_CFG_SVH
`define TCCP_CNT_W_DEF    32
`define TCCP_NCH_DEF      3
`define TCCP_MODE_W       2
`define TCCP_DT_W         8
`define TCCP_SYNC_STAGES  2
`endif

// ---- core/tccp_pkg.sv ----
// Purpose: types for the timer capture/compare/pwm block
// Assumes: nothing
// Notes:   one mode per channel
package tccp_pkg;
   typedef enum logic [1:0]
   {
      TCCP_MODE_CAPTURE = 2'h0,
      TCCP_MODE_COMPARE = 2'h1,
      TCCP_MODE_PWM     = 2'h3
   } tccp_mode_t;
endpackage

// ---- bench/tccp_evt_sink.sv ----
// Purpose: event network consumer of overflow strobes
// Assumes: strobes last one cycle
// Notes:   only tallies, never stalls the producer
`timescale 1ns/1ps
module tccp_evt_sink
(
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // producer strobe and tally
   input  wire logic ovf_evt,
   output int        n_ovf
);
   // tally each strobe once
   always_ff @(posedge clk)
   begin
      if (srst)
         n_ovf <= 0;
      else
         n_ovf <= n_ovf + int'(ovf_evt);
   end
endmodule

// ---- bench/tccp_timer_sva.sv ----
// Purpose: port assertions for tccp_timer
// Assumes: one clock, srst sync high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module tccp_timer_sva
#(
   parameter int CNT_W = 16
)
(
   // clock, reset, control
   input wire logic             clk,
   input wire logic             srst,
   input wire logic             cnt_en,
   input wire logic             cnt_ext_sel,
   input wire logic [CNT_W-1:0] top_val,
   // results
   input wire logic [CNT_W-1:0] cnt_val,
   input wire logic             ovf_flag,
   input wire logic             ern_ovf_evt,
   input wire logic [2:0]       ch_out,
   input wire logic [2:0]       ch_out_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // tick from the clock
   wire tk = cnt_en && !cnt_ext_sel;
   a_cnt_step: assert property (tk && cnt_val < top_val
      |=> cnt_val == $past(cnt_val) + 1'b1) else $error("no step");
   a_cnt_wrap: assert property (tk && cnt_val == top_val
      |=> cnt_val == '0) else $error("no wrap");
   a_cnt_hold: assert property (!cnt_en
      |=> $stable(cnt_val)) else $error("count moved");
   a_ovf_event: assert property (tk && cnt_val == top_val
      |-> ##[1:2] ern_ovf_evt) else $error("no strobe");
   a_evt_pulse: assert property (ern_ovf_evt
      |=> !ern_ovf_evt) else $error("long strobe");
   a_ovf_flag: assert property (ern_ovf_evt
      |-> ##[0:1] ovf_flag) else $error("flag not set");
   a_dt_gap: assert property (1'b1
      |-> (ch_out & ch_out_n) == 3'h0) else $error("both active");
   a_rst_clear: assert property (disable iff (1'b0) srst
      |=> cnt_val == '0 && !ovf_flag) else $error("reset");
   // main scenarios
   cover property (ern_ovf_evt);
   cover property (ch_out_n != 3'h0);
   cover property (tk && cnt_val == top_val);
endmodule

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for tccp_timer
// Assumes: 16-bit counter, three channels
// Notes:   compare and pwm cases come from tables
`timescale 1ns/1ps
module tb_top;
   import tccp_pkg::*;
   localparam int W = 16;
   // stimulus and results
   logic clk = 0, srst = 1, en = 0, xsel = 0, xpin = 0, clr = 0;
   logic [W-1:0] top = 3, cnt, p, capb[3];
   logic [W-1:0] cmp[3] = '{default: '0};
   tccp_mode_t mode[3] = '{default: TCCP_MODE_COMPARE};
   logic [2:0] wr = 0, cap = 0, vld, out, outn, evt;
   logic [7:0] dt = 0;
   logic ovf, oev;
   int miscompares = 0, samples_checked = 0, n_ovf, hi, lo;
   int rows[4][2] = '{'{0, 2}, '{1, 0}, '{2, 3}, '{0, 4}};
   int pw[2][2] = '{'{5, 0}, '{6, 1}};
   tccp_timer #(.CNT_W(W), .NCH(3)) tccp_timer_i (.clk(clk), .srst(srst),
      .cnt_en(en), .cnt_ext_sel(xsel), .ext_event_pin(xpin), .top_val(top),
      .cnt_val(cnt), .ovf_flag(ovf), .ovf_clr(clr), .ch_mode(mode),
      .ch_cmp_val(cmp), .ch_cmp_wr(wr), .dt_cycles(dt), .ch_cap_pin(cap),
      .ch_cap_buf(capb), .ch_cap_valid(vld), .ch_out(out), .ch_out_n(outn),
      .ern_ovf_evt(oev), .ern_ch_evt(evt));
   tccp_evt_sink tccp_evt_sink_i (.clk(clk), .srst(srst), .ovf_evt(oev),
      .n_ovf(n_ovf));
   // 100 MHz clock
   initial
      forever #5 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [W-1:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %0t %h %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("%0d checks, %0d bad", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // cut a hang short
   initial
   begin
      #20us;
      miscompares++;
      end_of_test;
   end
   // main sequence
   initial
   begin
      tick(2);
      srst = 0;
      chk({ovf, oev, out, outn, evt, vld}, 0);
      chk(cnt, 0);
      en = 1;
      tick(40);
      en = 0;
      tick(4);
      chk(n_ovf, 10);
      chk(ovf, 1);
      clr = 1;
      tick(1);
      clr = 0;
      chk(ovf, 0);
      $display("overflow done");
      en = 1;
      foreach (rows[i])
      begin
         cmp[rows[i][0]] = W'(rows[i][1]);
         wr = 3'h1 << rows[i][0];
         tick(1);
         wr = 0;
         tick(2);
         repeat (8)
         begin
            p = cnt;
            tick(1);
            chk(out[rows[i][0]], p >= rows[i][1]);
            chk(outn, 3'h0);
         end
      end
      $display("compare done");
      tick(1);
      en = 0;
      mode[0] = TCCP_MODE_CAPTURE;
      mode[1] = TCCP_MODE_CAPTURE;
      tick(1);
      p = cnt;
      cap = 3'h6;
      tick(3);
      chk(evt, 3'h2);
      tick(1);
      chk(evt, 3'h0);
      tick(1);
      chk(capb[1], p);
      chk(capb[0], 0);
      chk(vld, 3'h2);
      cap = 0;
      $display("capture done");
      en = 1;
      top = 9;
      mode[0] = TCCP_MODE_PWM;
      foreach (pw[i])
      begin
         cmp[0] = W'(pw[i][0]);
         dt = 8'(pw[i][1]);
         wr = 3'h1;
         tick(1);
         wr = 0;
         tick(30);
         hi = 0;
         lo = 0;
         repeat (40)
         begin
            tick(1);
            hi += out[0];
            lo += outn[0];
         end
         chk(hi, 4 * (pw[i][0] - pw[i][1] - 1));
         chk(lo, 4 * (9 - pw[i][0] - pw[i][1]));
      end
      $display("pwm done");
      srst = 1;
      tick(1);
      srst = 0;
      xsel = 1;
      top = 100;
      repeat (5)
      begin
         xpin = 1;
         tick(3);
         xpin = 0;
         tick(3);
      end
      chk(cnt, 5);
      chk(vld, 3'h0);
      $display("event count done");
      end_of_test;
   end
endmodule
bind tccp_timer tccp_timer_sva #(.CNT_W(CNT_W)) tccp_timer_sva_i (
   .clk(clk), .srst(srst), .cnt_en(cnt_en), .cnt_ext_sel(cnt_ext_sel),
   .top_val(top_val), .cnt_val(cnt_val), .ovf_flag(ovf_flag),
   .ern_ovf_evt(ern_ovf_evt), .ch_out(ch_out), .ch_out_n(ch_out_n));
